// [src/pdm_pkg.sv]
// Constants, register map and mode encodings for the power-down mode controller.
// Assumes a single 125 MHz clock domain and a 32-bit AXI4-Lite register port.
package pdm_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
	localparam logic [7:0] ADDR_TIMER_A = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;

	// power_control_one fields
	localparam int BIT_STANDBY_SELECT = 7;
	localparam int BIT_SETTLE_HI = 6;
	localparam int BIT_SETTLE_LO = 4;
	localparam int BIT_LOW_SPEED_ON = 3;
	localparam int BIT_MED_SEL_HI = 1;
	localparam int BIT_MED_SEL_LO = 0;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h07;
	localparam logic [7:0] CTRL_ONE_FIXED = 8'h04;

	// power_control_two fields
	localparam int BIT_NOISE_SEL = 4;
	localparam int BIT_DIRECT_ON = 3;
	localparam int BIT_MEDIUM_ON = 2;
	localparam int BIT_SUB_SEL_HI = 1;
	localparam int BIT_SUB_SEL_LO = 0;
	localparam logic [7:0] CTRL_TWO_RESET = 8'he0;
	localparam logic [7:0] CTRL_TWO_FIXED = 8'he0;

	// timer_a_mode_register: only the watch timer select bit lives here
	localparam int BIT_WATCH_TIMER = 3;

	// Status fields
	localparam int BIT_STAT_SETTLING = 4;

	// Settle counter width covers the longest wait
	typedef logic [17:0] pdm_settle_t;

	// Clock divide ratios
	localparam logic [7:0] DIV_NONE = 8'h00;
	localparam logic [7:0] DIV_1 = 8'h01;
	localparam logic [7:0] DIV_2 = 8'h02;
	localparam logic [7:0] DIV_4 = 8'h04;
	localparam logic [7:0] DIV_8 = 8'h08;
	localparam logic [7:0] DIV_16 = 8'h10;
	localparam logic [7:0] DIV_32 = 8'h20;
	localparam logic [7:0] DIV_64 = 8'h40;
	localparam logic [7:0] DIV_128 = 8'h80;

	// Clock source codes
	localparam logic [1:0] SRC_STOPPED = 2'h0;
	localparam logic [1:0] SRC_OSC = 2'h1;
	localparam logic [1:0] SRC_WATCH = 2'h2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		PDM_ACT_HIGH = 4'h0,
		PDM_ACT_MED = 4'h1,
		PDM_SUBACT = 4'h2,
		PDM_SLEEP_HIGH = 4'h3,
		PDM_SLEEP_MED = 4'h4,
		PDM_STANDBY = 4'h5,
		PDM_WATCH = 4'h6,
		PDM_SUBSLEEP = 4'h7,
		PDM_SETTLE = 4'h8
	} pdm_mode_e;

endpackage

// [src/pdm_power_down_mode_controller.sv]
// Power-down mode controller: mode state machine, settle timer, clock selection,
// AXI4-Lite control registers.
// Assumes interrupt requests and enables come from logic on the same clock; the
// reset pin is asynchronous and is filtered here.
module pdm_power_down_mode_controller #(
	parameter int unsigned SETTLE_STATES_0 = 8192,
	parameter int unsigned SETTLE_STATES_1 = 16384,
	parameter int unsigned SETTLE_STATES_2 = 32768,
	parameter int unsigned SETTLE_STATES_3 = 65536,
	parameter int unsigned SETTLE_STATES_4 = 131072
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic resetPinN,
	input wire logic sleepExec,
	input wire logic interruptMask,
	input wire logic [3:0] extIrq,
	input wire logic [3:0] extIrqEn,
	input wire logic [7:0] keyIrq,
	input wire logic [7:0] keyIrqEn,
	input wire logic timerAIrq,
	input wire logic timerAIrqEn,
	input wire logic otherIrq,
	input wire logic directIrqEn,
	output logic cpuReset,
	output logic cpuHalt,
	output logic exceptionStart,
	output logic directTransferIrq,
	output logic [1:0] clockSource,
	output logic [7:0] clockDivide,
	output logic oscEnable,
	output logic periphClockEnable,
	output logic pwmClockEnable,
	output logic timerAClockEnable,
	output logic timerCClockEnable,
	output logic portsHiZ,
	output logic portsHold,
	output logic [3:0] modeState,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// Settle length for a select code; top bit set always picks the longest
	function automatic pdm_pkg::pdm_settle_t settleLength(input logic [2:0] sel);
		if (sel[2]) settleLength = pdm_pkg::pdm_settle_t'(SETTLE_STATES_4);
		else case (sel[1:0])
			2'h0: settleLength = pdm_pkg::pdm_settle_t'(SETTLE_STATES_0);
			2'h1: settleLength = pdm_pkg::pdm_settle_t'(SETTLE_STATES_1);
			2'h2: settleLength = pdm_pkg::pdm_settle_t'(SETTLE_STATES_2);
			default: settleLength = pdm_pkg::pdm_settle_t'(SETTLE_STATES_3);
		endcase
	endfunction

	// Plain SLEEP entries; an unlisted combination leaves the mode alone
	function automatic pdm_pkg::pdm_mode_e plainEntry(input pdm_pkg::pdm_mode_e cur,
			input logic standby_select, input logic low_speed_on, input logic medium_speed_on, input logic watch_timer_select);
		plainEntry = cur;
		if (standby_select && watch_timer_select) plainEntry = pdm_pkg::PDM_WATCH;
		else if (cur == pdm_pkg::PDM_SUBACT) begin
			if (!standby_select && low_speed_on && watch_timer_select) plainEntry = pdm_pkg::PDM_SUBSLEEP;
		end else if (!standby_select && !low_speed_on) begin
			plainEntry = medium_speed_on ? pdm_pkg::PDM_SLEEP_MED : pdm_pkg::PDM_SLEEP_HIGH;
		end else if (standby_select && !low_speed_on && !watch_timer_select) begin
			plainEntry = pdm_pkg::PDM_STANDBY;
		end
	endfunction

	// Direct transfer target among running modes; returns cur when none matches
	function automatic pdm_pkg::pdm_mode_e directEntry(input pdm_pkg::pdm_mode_e cur,
			input logic standby_select, input logic low_speed_on, input logic medium_speed_on, input logic watch_timer_select);
		directEntry = cur;
		if (cur == pdm_pkg::PDM_SUBACT) begin
			if (standby_select && watch_timer_select && !low_speed_on)
				directEntry = medium_speed_on ? pdm_pkg::PDM_ACT_MED : pdm_pkg::PDM_ACT_HIGH;
		end else if (standby_select && watch_timer_select && low_speed_on) begin
			directEntry = pdm_pkg::PDM_SUBACT;
		end else if (!standby_select && !low_speed_on) begin
			directEntry = medium_speed_on ? pdm_pkg::PDM_ACT_MED : pdm_pkg::PDM_ACT_HIGH;
		end
	endfunction

	// Control registers
	logic [7:0] ctrlOne;
	logic [7:0] ctrlTwo;
	logic watchTimerSelect;
	wire standbySelect = ctrlOne[pdm_pkg::BIT_STANDBY_SELECT];
	wire lowSpeedOn = ctrlOne[pdm_pkg::BIT_LOW_SPEED_ON];
	wire [2:0] settleSel = ctrlOne[pdm_pkg::BIT_SETTLE_HI:pdm_pkg::BIT_SETTLE_LO];
	wire [1:0] medSel = ctrlOne[pdm_pkg::BIT_MED_SEL_HI:pdm_pkg::BIT_MED_SEL_LO];
	wire directOn = ctrlTwo[pdm_pkg::BIT_DIRECT_ON];
	wire mediumOn = ctrlTwo[pdm_pkg::BIT_MEDIUM_ON];
	wire [1:0] subSel = ctrlTwo[pdm_pkg::BIT_SUB_SEL_HI:pdm_pkg::BIT_SUB_SEL_LO];

	// Reset pin filter: a change counts once the last two stages agree
	logic pinSync1;
	logic pinSync2;
	logic pinSync3;
	logic pinLevel;
	always_ff @(posedge clock) begin
		if (reset) begin
			pinSync1 <= 1'b1;
			pinSync2 <= 1'b1;
			pinSync3 <= 1'b1;
			pinLevel <= 1'b1;
		end else begin
			pinSync1 <= resetPinN;
			pinSync2 <= pinSync1;
			pinSync3 <= pinSync2;
			if (pinSync2 == pinSync3) pinLevel <= pinSync3;
		end
	end
	wire pinLow = !pinLevel;

	// Wake sources, each gated by the interrupt mask and, except otherIrq, by its enable
	wire unmasked = !interruptMask;
	wire [3:0] extOn = extIrq & extIrqEn;
	wire keyOn = |(keyIrq & keyIrqEn);
	wire timerAOn = timerAIrq && timerAIrqEn;
	wire sleepWake = unmasked && (|extOn || keyOn || timerAOn || otherIrq);
	wire standbyWake = unmasked && (extOn[1] || extOn[0]);
	wire watchWake = unmasked && (timerAOn || extOn[0]);
	wire subsleepWake = unmasked && (timerAOn || |extOn || keyOn);
	wire directAllowed = directOn && unmasked && directIrqEn;

	pdm_pkg::pdm_mode_e mode;
	pdm_pkg::pdm_mode_e next_mode;
	pdm_pkg::pdm_mode_e settleTarget;
	pdm_pkg::pdm_mode_e next_settleTarget;
	pdm_pkg::pdm_settle_t settleCount;
	logic settleDirect;
	logic next_settleDirect;
	logic loadSettle;
	logic next_exception;
	logic next_directIrq;
	wire pdm_pkg::pdm_mode_e plainMode = plainEntry(mode, standbySelect, lowSpeedOn,
		mediumOn, watchTimerSelect);
	wire pdm_pkg::pdm_mode_e directMode = directEntry(mode, standbySelect, lowSpeedOn,
		mediumOn, watchTimerSelect);
	wire settleDone = (mode == pdm_pkg::PDM_SETTLE) && (settleCount == '0);
	wire pdm_pkg::pdm_mode_e speedMode = mediumOn ? pdm_pkg::PDM_ACT_MED :
		pdm_pkg::PDM_ACT_HIGH;

	// Mode transitions; wakes not listed for the current mode fall through
	always_comb begin
		next_mode = mode;
		next_settleTarget = settleTarget;
		next_settleDirect = settleDirect;
		loadSettle = 1'b0;
		next_exception = 1'b0;
		next_directIrq = 1'b0;
		if (pinLow) begin
			next_mode = pdm_pkg::PDM_ACT_HIGH;
		end else case (mode)
			pdm_pkg::PDM_ACT_HIGH, pdm_pkg::PDM_ACT_MED, pdm_pkg::PDM_SUBACT: begin
				if (sleepExec && directAllowed && directMode != mode) begin
					if (mode == pdm_pkg::PDM_SUBACT) begin
						next_mode = pdm_pkg::PDM_SETTLE;
						next_settleTarget = directMode;
						next_settleDirect = 1'b1;
						loadSettle = 1'b1;
					end else begin
						next_mode = directMode;
						next_directIrq = 1'b1;
					end
				end else if (sleepExec) begin
					next_mode = plainMode;
				end
			end
			pdm_pkg::PDM_SLEEP_HIGH, pdm_pkg::PDM_SLEEP_MED: begin
				if (sleepWake) begin
					next_mode = (mode == pdm_pkg::PDM_SLEEP_MED) ? pdm_pkg::PDM_ACT_MED :
						pdm_pkg::PDM_ACT_HIGH;
					next_exception = 1'b1;
				end
			end
			pdm_pkg::PDM_STANDBY: begin
				if (standbyWake) begin
					next_mode = pdm_pkg::PDM_SETTLE;
					next_settleTarget = speedMode;
					next_settleDirect = 1'b0;
					loadSettle = 1'b1;
				end
			end
			pdm_pkg::PDM_WATCH: begin
				if (watchWake && lowSpeedOn) begin
					next_mode = pdm_pkg::PDM_SUBACT;
					next_exception = 1'b1;
				end else if (watchWake) begin
					next_mode = pdm_pkg::PDM_SETTLE;
					next_settleTarget = speedMode;
					next_settleDirect = 1'b0;
					loadSettle = 1'b1;
				end
			end
			pdm_pkg::PDM_SUBSLEEP: begin
				if (subsleepWake) begin
					next_mode = pdm_pkg::PDM_SUBACT;
					next_exception = 1'b1;
				end
			end
			pdm_pkg::PDM_SETTLE: begin
				if (settleDone) begin
					next_mode = settleTarget;
					next_exception = !settleDirect;
					next_directIrq = settleDirect;
				end
			end
			default: next_mode = pdm_pkg::PDM_ACT_HIGH;
		endcase
	end

	// Mode register and pulses; reset lands in active high-speed
	always_ff @(posedge clock) begin
		if (reset) begin
			mode <= pdm_pkg::PDM_ACT_HIGH;
			settleTarget <= pdm_pkg::PDM_ACT_HIGH;
			settleDirect <= 1'b0;
			exceptionStart <= 1'b0;
			directTransferIrq <= 1'b0;
		end else begin
			mode <= next_mode;
			settleTarget <= next_settleTarget;
			settleDirect <= next_settleDirect;
			exceptionStart <= next_exception;
			directTransferIrq <= next_directIrq;
		end
	end

	// Settle counter in clock states, loaded on a standby wake, on a watch wake with low speed off, and on a direct move out of subactive
	always_ff @(posedge clock) begin
		if (reset) settleCount <= '0;
		else if (loadSettle) settleCount <= settleLength(settleSel) - 1'b1;
		else if (mode == pdm_pkg::PDM_SETTLE && settleCount != '0)
			settleCount <= settleCount - 1'b1;
	end

	// Medium and subactive divide choices
	wire [7:0] medDivide = (medSel == 2'h0) ? pdm_pkg::DIV_16 :
		(medSel == 2'h1) ? pdm_pkg::DIV_32 :
		(medSel == 2'h2) ? pdm_pkg::DIV_64 : pdm_pkg::DIV_128;
	wire [7:0] subDivide = subSel[1] ? pdm_pkg::DIV_2 :
		subSel[0] ? pdm_pkg::DIV_4 : pdm_pkg::DIV_8;

	// Clock and port controls decoded from the next mode so they align with modeState
	logic [1:0] next_source;
	logic [7:0] next_divide;
	logic next_halt;
	logic next_periph;
	logic next_pwm;
	logic next_timerA;
	logic next_timerC;
	logic next_osc;
	logic next_hiZ;
	logic next_hold;
	always_comb begin
		next_source = pdm_pkg::SRC_OSC;
		next_divide = pdm_pkg::DIV_1;
		next_halt = 1'b0;
		next_periph = 1'b1;
		next_pwm = 1'b1;
		next_timerA = 1'b1;
		next_timerC = 1'b1;
		next_osc = 1'b1;
		next_hiZ = 1'b0;
		next_hold = 1'b0;
		case (next_mode)
			pdm_pkg::PDM_ACT_HIGH: next_divide = pdm_pkg::DIV_1;
			pdm_pkg::PDM_ACT_MED: next_divide = medDivide;
			pdm_pkg::PDM_SUBACT: begin
				next_source = pdm_pkg::SRC_WATCH;
				next_divide = subDivide;
			end
			pdm_pkg::PDM_SLEEP_HIGH, pdm_pkg::PDM_SLEEP_MED: begin
				next_halt = 1'b1;
				next_pwm = 1'b0;
				if (next_mode == pdm_pkg::PDM_SLEEP_MED) next_divide = medDivide;
			end
			pdm_pkg::PDM_STANDBY: begin
				next_source = pdm_pkg::SRC_STOPPED;
				next_divide = pdm_pkg::DIV_NONE;
				next_halt = 1'b1;
				next_periph = 1'b0;
				next_pwm = 1'b0;
				next_timerA = 1'b0;
				next_timerC = 1'b0;
				next_osc = 1'b0;
				next_hiZ = 1'b1;
			end
			pdm_pkg::PDM_WATCH, pdm_pkg::PDM_SUBSLEEP, pdm_pkg::PDM_SETTLE: begin
				next_source = pdm_pkg::SRC_STOPPED;
				next_divide = pdm_pkg::DIV_NONE;
				next_halt = 1'b1;
				next_periph = 1'b0;
				next_pwm = 1'b0;
				next_timerC = (next_mode == pdm_pkg::PDM_SUBSLEEP);
				next_osc = (next_mode == pdm_pkg::PDM_SETTLE);
				next_hold = 1'b1;
			end
			default: next_halt = 1'b0;
		endcase
		if (pinLow) next_osc = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			clockSource <= pdm_pkg::SRC_OSC;
			clockDivide <= pdm_pkg::DIV_1;
			{cpuHalt, portsHiZ, portsHold, cpuReset} <= 4'h0;
			{periphClockEnable, pwmClockEnable, oscEnable} <= 3'h7;
			{timerAClockEnable, timerCClockEnable} <= 2'h3;
			modeState <= pdm_pkg::PDM_ACT_HIGH;
		end else begin
			clockSource <= next_source;
			clockDivide <= next_divide;
			{cpuHalt, portsHiZ, portsHold, cpuReset} <= {next_halt, next_hiZ, next_hold, pinLow};
			{periphClockEnable, pwmClockEnable, oscEnable} <= {next_periph, next_pwm, next_osc};
			{timerAClockEnable, timerCClockEnable} <= {next_timerA, next_timerC};
			modeState <= next_mode;
		end
	end

	// AXI4-Lite write side: address and data taken in either order
	logic awHeld;
	logic wHeld;
	logic [7:0] wAddr;
	logic [7:0] wByte;
	logic wLane;
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire doWrite = awHeld && wHeld && !s_axi_bvalid;
	wire writeHit = (wAddr == pdm_pkg::ADDR_CTRL_ONE) || (wAddr == pdm_pkg::ADDR_CTRL_TWO) ||
		(wAddr == pdm_pkg::ADDR_TIMER_A) || (wAddr == pdm_pkg::ADDR_STATUS);
	wire inSubact = (mode == pdm_pkg::PDM_SUBACT);
	always_ff @(posedge clock) begin
		if (reset) begin
			{awHeld, wHeld, s_axi_bvalid} <= 3'h0;
			{s_axi_awready, s_axi_wready} <= 2'h3;
			{wAddr, wByte, wLane} <= '0;
			s_axi_bresp <= pdm_pkg::RESP_OKAY;
		end else begin
			if (awTake) {awHeld, s_axi_awready, wAddr} <= {2'h2, s_axi_awaddr[7:0]};
			if (wTake) {wHeld, s_axi_wready, wByte, wLane} <= {2'h2, s_axi_wdata[7:0], s_axi_wstrb[0]};
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= writeHit ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
				{s_axi_bvalid, awHeld, wHeld, s_axi_awready, s_axi_wready} <= 5'h03;
		end
	end

	// Register stores; fixed bits read as one, sub select frozen in subactive
	wire wrOne = doWrite && wLane && (wAddr == pdm_pkg::ADDR_CTRL_ONE);
	wire wrTwo = doWrite && wLane && (wAddr == pdm_pkg::ADDR_CTRL_TWO);
	wire wrTma = doWrite && wLane && (wAddr == pdm_pkg::ADDR_TIMER_A);
	wire [7:0] twoKeep = inSubact ? (pdm_pkg::CTRL_TWO_FIXED | 8'h03) : pdm_pkg::CTRL_TWO_FIXED;
	always_ff @(posedge clock) begin
		if (reset) begin
			ctrlOne <= pdm_pkg::CTRL_ONE_RESET;
			ctrlTwo <= pdm_pkg::CTRL_TWO_RESET;
			watchTimerSelect <= 1'b0;
		end else begin
			if (wrOne) ctrlOne <= wByte | pdm_pkg::CTRL_ONE_FIXED;
			if (wrTwo) ctrlTwo <= (wByte & ~twoKeep) | (ctrlTwo & twoKeep);
			if (wrTma) watchTimerSelect <= wByte[pdm_pkg::BIT_WATCH_TIMER];
		end
	end

	// AXI4-Lite read side, answer one cycle after the address is taken
	wire [7:0] rAddr = s_axi_araddr[7:0];
	wire [31:0] statusWord = {27'h0, (mode == pdm_pkg::PDM_SETTLE), mode};
	wire [31:0] readWord = (rAddr == pdm_pkg::ADDR_CTRL_ONE) ? {24'h0, ctrlOne} :
		(rAddr == pdm_pkg::ADDR_CTRL_TWO) ? {24'h0, ctrlTwo} :
		(rAddr == pdm_pkg::ADDR_TIMER_A) ? {28'h0, watchTimerSelect, 3'h0} :
		(rAddr == pdm_pkg::ADDR_STATUS) ? statusWord : 32'h0;
	wire readHit = (rAddr == pdm_pkg::ADDR_CTRL_ONE) || (rAddr == pdm_pkg::ADDR_CTRL_TWO) ||
		(rAddr == pdm_pkg::ADDR_TIMER_A) || (rAddr == pdm_pkg::ADDR_STATUS);
	always_ff @(posedge clock) begin
		if (reset) begin
			{s_axi_arready, s_axi_rvalid} <= 2'h2;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= pdm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			{s_axi_arready, s_axi_rvalid} <= 2'h1;
			s_axi_rdata <= readWord;
			s_axi_rresp <= readHit ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			{s_axi_arready, s_axi_rvalid} <= 2'h2;
		end
	end

	// Checks on the mode machine
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	wire isActive = (mode == pdm_pkg::PDM_ACT_HIGH) || (mode == pdm_pkg::PDM_ACT_MED);
	a_sleep_high_entry: assert property (isActive && sleepExec && !pinLow &&
		!standbySelect && !lowSpeedOn && !mediumOn && !directOn |=>
		mode == pdm_pkg::PDM_SLEEP_HIGH)
		else $error("sleep high-speed not entered");
	a_sleep_med_entry: assert property (isActive && sleepExec && !pinLow &&
		!standbySelect && !lowSpeedOn && mediumOn && !directOn |=>
		mode == pdm_pkg::PDM_SLEEP_MED)
		else $error("sleep medium-speed not entered");
	a_sleep_clock_gating: assert property ((mode == pdm_pkg::PDM_SLEEP_MED) |->
		cpuHalt && periphClockEnable && !pwmClockEnable && clockDivide == medDivide)
		else $error("sleep clocks wrong");
	a_sleep_wake_speed: assert property (mode == pdm_pkg::PDM_SLEEP_HIGH &&
		sleepWake && !pinLow |=> mode == pdm_pkg::PDM_ACT_HIGH && exceptionStart)
		else $error("sleep wake wrong");
	a_masked_no_wake: assert property (interruptMask && !pinLow && !isActive &&
		mode != pdm_pkg::PDM_SUBACT && mode != pdm_pkg::PDM_SETTLE |=> $stable(mode))
		else $error("masked interrupt woke device");
	a_pin_reset_mode: assert property (pinLow |=> mode == pdm_pkg::PDM_ACT_HIGH &&
		cpuReset && oscEnable)
		else $error("pin reset not honoured");
	a_standby_ports: assert property (mode == pdm_pkg::PDM_STANDBY |-> portsHiZ &&
		!oscEnable && clockSource == pdm_pkg::SRC_STOPPED)
		else $error("standby outputs wrong");
	a_settle_load: assert property (loadSettle |=>
		settleCount == settleLength($past(settleSel)) - 1'b1)
		else $error("settle count loaded wrong");
	a_settle_exit: assert property (settleDone && !settleDirect && !pinLow |=>
		exceptionStart && mode == $past(settleTarget))
		else $error("settle exit wrong");
	a_subactive_divide: assert property (mode == pdm_pkg::PDM_SUBACT |->
		clockSource == pdm_pkg::SRC_WATCH && clockDivide == subDivide)
		else $error("subactive clock wrong");
	c_standby_wake: cover property (mode == pdm_pkg::PDM_STANDBY ##1
		mode == pdm_pkg::PDM_SETTLE);
	c_watch_to_sub: cover property (mode == pdm_pkg::PDM_WATCH ##1 mode == pdm_pkg::PDM_SUBACT);
	c_subsleep_wake: cover property (mode == pdm_pkg::PDM_SUBSLEEP ##1 exceptionStart);
	c_direct_move: cover property (directTransferIrq);

endmodule

// [testbench/pdm_cpu_model.sv]
// CPU-side partner: SLEEP pulses and the reset pin.
// Assumes its tasks are called from the bench's main process only.
module pdm_cpu_model (
	input wire logic clock,
	output logic sleepExec,
	output logic resetPinN
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sleepExec = 1'b0;
		resetPinN = 1'b1;
	end
	// One-cycle SLEEP pulse, changed only after an edge
	task automatic sleep();
		@(posedge clock) sleepExec <= 1'b1;
		@(posedge clock) sleepExec <= 1'b0;
	endtask
	// Pin stays low past the oscillator settle, so the clock is stable at release
	task automatic pinReset(input int hold);
		@(posedge clock) resetPinN <= 1'b0;
		repeat (hold) @(posedge clock);
		resetPinN <= 1'b1;
	endtask
endmodule

// [testbench/power_down_mode_controller_tb.sv]
// Bench for the power-down mode controller: register setup, mode entry, wake.
// Assumes settle counts shrunk to 8 << code so each wait stays short.
module power_down_mode_controller_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, reset = 1'b1, mask = 1'b0, otherIrq = 1'b0, timerAIrq = 1'b0;
	logic [3:0] extIrq = 4'h0;
	logic [7:0] keyIrq = 8'h00;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic sleepExec, resetPinN, cpuReset, cpuHalt, exc, pwm, periph, hiZ, hold;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] clockSource, rresp, bresp, expWr[$];
	logic dti, osc, tA, tC, dirEn = 1'b0;
	logic [3:0] strb = 4'hf;
	logic [7:0] clockDivide;
	logic [3:0] modeState, last;
	logic [31:0] rdata;
	logic [33:0] expMode[$], expRd[$];
	int fail_count = 0, n_compared = 0, cyc = 0, n, n2;
	pdm_cpu_model i_cpu (.clock(clock), .sleepExec(sleepExec), .resetPinN(resetPinN));
	pdm_power_down_mode_controller #(.SETTLE_STATES_0(8), .SETTLE_STATES_1(16),
		.SETTLE_STATES_2(32), .SETTLE_STATES_3(64), .SETTLE_STATES_4(128)) i_dut (
		.clock(clock), .reset(reset), .resetPinN(resetPinN), .sleepExec(sleepExec),
		.interruptMask(mask), .extIrq(extIrq), .extIrqEn(extIrq), .keyIrq(keyIrq),
		.keyIrqEn(keyIrq), .timerAIrq(timerAIrq), .timerAIrqEn(timerAIrq),
		.otherIrq(otherIrq), .directIrqEn(dirEn), .cpuReset(cpuReset), .cpuHalt(cpuHalt),
		.exceptionStart(exc), .directTransferIrq(dti), .clockSource(clockSource),
		.clockDivide(clockDivide), .oscEnable(osc), .periphClockEnable(periph),
		.pwmClockEnable(pwm), .timerAClockEnable(tA), .timerCClockEnable(tC),
		.portsHiZ(hiZ), .portsHold(hold), .modeState(modeState),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial forever #4 clock = ~clock;
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Watchdog; the whole run needs a few hundred cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			final_report();
		end
	end
	// Monitor: every mode change and read answer consumes the oldest note
	always @(posedge clock) begin
		if (rvalid && rready) check({rresp, rdata}, expRd.size() ? expRd.pop_front() : 'x);
		if (bvalid && bready) check(bresp, expWr.size() ? expWr.pop_front() : 'x);
		if (reset) last = 4'h0;
		else if (modeState !== last) begin
			check({dti, exc, modeState}, expMode.size() ? expMode.pop_front() : 'x);
			last = modeState;
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		// Offsets past the status word are unmapped and answer with an error
		expWr.push_back((a > pdm_pkg::ADDR_STATUS) ? pdm_pkg::RESP_SLVERR : pdm_pkg::RESP_OKAY);
		@(posedge clock);
		awaddr <= {24'h0, a};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		expRd.push_back(e);
		@(posedge clock);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask
	task automatic waitMode(input logic [3:0] m);
		for (int i = 0; i < 300 && modeState !== m; i++) @(posedge clock);
	endtask
	task automatic go(input logic [7:0] c1, c2, timer_a_mode_register, input logic [5:0] m);
		wr(8'h00, c1);
		wr(8'h04, c2);
		wr(8'h08, timer_a_mode_register);
		expMode.push_back(m);
		i_cpu.sleep();
		waitMode(m[3:0]);
	endtask
	// Wake is already requested by the caller; requests drop once the mode lands
	task automatic wake(input logic [3:0] m);
		expMode.push_back({1'b1, m});
		waitMode(m);
		@(posedge clock);
		extIrq <= 4'h0;
		keyIrq <= 8'h00;
		timerAIrq <= 1'b0;
	endtask
	initial begin
		void'($urandom(32'hff89));
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		// Lane 0 strobe low: the write is answered but must not land
		strb <= 4'h0;
		wr(8'h00, 8'hf0);
		strb <= 4'hf;
		wr(8'h10, 8'hff);
		rd(8'h00, {pdm_pkg::RESP_OKAY, 24'h0, pdm_pkg::CTRL_ONE_RESET});
		rd(8'h04, {pdm_pkg::RESP_OKAY, 24'h0, pdm_pkg::CTRL_TWO_RESET});
		rd(8'h10, {pdm_pkg::RESP_SLVERR, 32'h0});
		go(8'h01, 8'he4, 8'h00, pdm_pkg::PDM_SLEEP_MED);
		check(clockDivide, pdm_pkg::DIV_32);
		check({cpuHalt, pwm, periph}, 3'b101);
		rd(8'h00, {pdm_pkg::RESP_OKAY, 32'h05});
		@(posedge clock) extIrq <= 4'h4;
		wake(pdm_pkg::PDM_ACT_MED);
		go(8'h03, 8'he0, 8'h00, pdm_pkg::PDM_SLEEP_HIGH);
		@(posedge clock) mask <= 1'b1;
		extIrq <= 4'h1;
		// Masked request must leave the mode alone
		repeat (8) @(posedge clock);
		mask <= 1'b0;
		wake(pdm_pkg::PDM_ACT_HIGH);
		n = $urandom % 5;
		go(8'(8'h83 | (n << 4)), 8'he0, 8'h00, pdm_pkg::PDM_STANDBY);
		check({hiZ, osc}, 2'b10);
		// Both notes go in first: the target lands in the edge that ends the count
		expMode.push_back({1'b0, pdm_pkg::PDM_SETTLE});
		expMode.push_back({1'b1, pdm_pkg::PDM_ACT_HIGH});
		@(posedge clock) extIrq <= 4'h2;
		waitMode(pdm_pkg::PDM_SETTLE);
		n2 = 0;
		while (modeState === pdm_pkg::PDM_SETTLE && n2 < 300) begin
			@(posedge clock);
			n2++;
		end
		check(n2, 8 << n);
		@(posedge clock) extIrq <= 4'h0;
		go(8'h88, 8'he0, 8'h08, pdm_pkg::PDM_WATCH);
		check({hold, tA, tC}, 3'b110);
		@(posedge clock) timerAIrq <= 1'b1;
		wake(pdm_pkg::PDM_SUBACT);
		check({clockSource, clockDivide}, {pdm_pkg::SRC_WATCH, pdm_pkg::DIV_8});
		go(8'h08, 8'he0, 8'h08, pdm_pkg::PDM_SUBSLEEP);
		check({tA, tC}, 2'b11);
		@(posedge clock) otherIrq <= 1'b1;
		repeat (6) @(posedge clock);
		otherIrq <= 1'b0;
		keyIrq <= 8'h01 << ($urandom % 8);
		wake(pdm_pkg::PDM_SUBACT);
		expMode.push_back({1'b0, pdm_pkg::PDM_ACT_HIGH});
		i_cpu.pinReset(10);
		check(cpuReset, 1'b1);
		repeat (8) @(posedge clock);
		check(cpuReset, 1'b0);
		// Direct move to medium speed pulses the direct interrupt, no exception
		dirEn <= 1'b1;
		go(8'h00, 8'hec, 8'h00, {2'b10, pdm_pkg::PDM_ACT_MED});
		@(posedge clock) check(expMode.size() + expRd.size() + expWr.size(), 0);
		final_report();
	end
endmodule
